// ===== bench/atc_seq_model.sv
// Acquisition sequencer model that takes samples while conversion runs
`timescale 1ns/1ns
module atc_seq_model (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic slowMode,
  input wire logic convertEnable,
  output logic sampleTaken
);
  // --------------------------------
  // Readiness
  // --------------------------------
  logic phase; // Alternates each cycle, used to stall in slow mode

  // Toggle readiness phase
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      phase <= 1'b0;
    end else begin
      phase <= ~phase;
    end
  end

  // Take a sample only while conversion is enabled; slow mode skips every other cycle
  assign sampleTaken = convertEnable & (~slowMode | phase);
endmodule

// ===== bench/atc_trigger_control_test.sv
// Self-checking bench for the acquisition trigger controller
`timescale 1ns/1ns
`define CHK(g, e) chk(32'(g), 32'(e))
module atc_trigger_control_test;
  // --------------------------------
  // Stimulus and observation
  // --------------------------------
  typedef struct {
    logic [1:0] src, typ, cond;
    logic [2:0] asel;
    logic dsel, neg;
    logic signed [15:0] val;
    logic [23:0] pts;
    logic expTrig;
  } atc_row_t;
  logic ref_clk = 0, rstn = 0, start = 0, abort = 0, continuousMode = 0, timebaseTick = 0, slowMode = 0;
  logic [1:0] triggerSource = 0, triggerType = 0, analogCondition = 0;
  logic digitalSelectOutputSide = 0, digitalNegative = 0, starTrigger = 0;
  logic inputSideDigitalTriggerPin = 0, outputSideDigitalTriggerPin = 0;
  logic [2:0] analogSelect = 0;
  // Thresholds keep high above low, as the configuring side must
  logic signed [15:0] highThreshold = 16'sh0032, lowThreshold = 16'shFFCE;
  logic signed [15:0] anaIn [5] = '{default: 16'sh0000}; // Pin then channels one..four
  logic [4:0] sampleValid = 0;
  logic [23:0] samplePoints = 0;
  logic [30:0] delayPreset = 0, delayRemaining;
  logic sampleTaken, convertEnable, triggered, busy, done, configError;
  int errCount = 0, numChecks = 0, takenCount = 0, trigCount = 0, doneCount = 0;
  // Ordinary cases: source, type, condition, analog select, pin side, falling, value, points, fires
  atc_row_t rows [11] = '{
    '{2'h0, 2'h0, 2'h0, 3'h0, 1'b0, 1'b0, 16'sh0000, 24'h000003, 1'b1},
    '{2'h1, 2'h0, 2'h0, 3'h0, 1'b0, 1'b0, 16'sh0000, 24'h000002, 1'b1},
    '{2'h1, 2'h0, 2'h0, 3'h0, 1'b1, 1'b1, 16'sh0000, 24'h000004, 1'b1},
    '{2'h2, 2'h0, 2'h0, 3'h0, 1'b0, 1'b0, 16'sh0064, 24'h000001, 1'b1},
    '{2'h2, 2'h0, 2'h0, 3'h2, 1'b0, 1'b0, 16'sh0032, 24'h000001, 1'b0},
    '{2'h2, 2'h0, 2'h1, 3'h4, 1'b0, 1'b0, 16'shFFC4, 24'h000002, 1'b1},
    '{2'h2, 2'h0, 2'h1, 3'h3, 1'b0, 1'b0, 16'shFFCE, 24'h000001, 1'b0},
    '{2'h2, 2'h0, 2'h2, 3'h1, 1'b0, 1'b0, 16'sh0000, 24'h000002, 1'b1},
    '{2'h2, 2'h0, 2'h2, 3'h3, 1'b0, 1'b0, 16'sh0032, 24'h000001, 1'b0},
    '{2'h3, 2'h0, 2'h0, 3'h0, 1'b0, 1'b0, 16'sh0000, 24'h000003, 1'b1},
    '{2'h2, 2'h0, 2'h3, 3'h1, 1'b0, 1'b0, 16'sh0064, 24'h000001, 1'b0}};

  atc_trigger_control uut (.ref_clk, .rstn, .start, .abort, .continuousMode, .triggerSource, .triggerType,
    .digitalSelectOutputSide, .digitalNegative, .analogSelect, .analogCondition, .highThreshold, .lowThreshold,
    .samplePoints, .delayPreset, .timebaseTick, .inputSideDigitalTriggerPin, .outputSideDigitalTriggerPin,
    .starTrigger, .externalAnalogTriggerPin(anaIn[0]), .analogChannelOne(anaIn[1]), .analogChannelTwo(anaIn[2]),
    .analogChannelThree(anaIn[3]), .analogChannelFour(anaIn[4]), .sampleValid, .sampleTaken, .convertEnable,
    .triggered, .busy, .done, .configError, .delayRemaining);
  atc_seq_model seq (.ref_clk, .rstn, .slowMode, .convertEnable, .sampleTaken);

  // Clock at 125 MHz
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  // Timebase ticks every other cycle, count of pulses seen
  always @(posedge ref_clk) begin
    if (sampleTaken) takenCount++;
    if (triggered) trigCount++;
    if (done) doneCount++;
    #1 timebaseTick = ~timebaseTick;
  end

  // --------------------------------
  // Helpers
  // --------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      errCount++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    step(1);
    s = 0;
  endtask
  // Wait bounded for a pulse counter to move past its base
  task automatic waitCnt(ref int c, input int base, input int lim);
    for (int i = 0; i < lim && c == base; i++) step(1);
    `CHK(c != base, 1);
  endtask
  task automatic setup(input atc_row_t r);
    triggerSource = r.src; triggerType = r.typ; analogCondition = r.cond; analogSelect = r.asel;
    digitalSelectOutputSide = r.dsel; digitalNegative = r.neg; samplePoints = r.pts;
    inputSideDigitalTriggerPin = r.neg; outputSideDigitalTriggerPin = r.neg; starTrigger = 0;
    anaIn = '{default: 16'sh0000};
    anaIn[r.asel] = r.val;
  endtask
  task automatic endSim();
    $display("checks %0d mismatches %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    #80000;
    errCount++;
    endSim();
  end

  // --------------------------------
  // Tests
  // --------------------------------
  initial begin
    int t0, tr0, d0, cyc;
    logic [30:0] mx;
    step(10);
    rstn = 1;
    // Table of sources, pins and conditions
    foreach (rows[i]) begin
      setup(rows[i]);
      slowMode = i[0];
      t0 = takenCount; tr0 = trigCount; d0 = doneCount;
      pulse(start);
      // Decoys: wrong pin edge, other channels sampled, selected value not yet fresh
      if (rows[i].dsel) inputSideDigitalTriggerPin = ~rows[i].neg;
      else outputSideDigitalTriggerPin = ~rows[i].neg;
      if (rows[i].src == 2'h2) sampleValid = ~(5'h01 << rows[i].asel);
      step(1);
      sampleValid = 0;
      step(4);
      `CHK(trigCount - tr0, rows[i].src == 2'h0);
      if (rows[i].src == 2'h1 && rows[i].dsel) outputSideDigitalTriggerPin = ~rows[i].neg;
      if (rows[i].src == 2'h1 && !rows[i].dsel) inputSideDigitalTriggerPin = ~rows[i].neg;
      if (rows[i].src == 2'h2) sampleValid = 5'h01 << rows[i].asel;
      if (rows[i].src == 2'h3) starTrigger = 1;
      step(1);
      sampleValid = 0;
      if (rows[i].expTrig) begin
        waitCnt(doneCount, d0, 60);
        `CHK(trigCount - tr0, 1);
        `CHK(takenCount - t0, rows[i].pts);
        `CHK(convertEnable, 0);
      end else begin
        step(10);
        `CHK(trigCount - tr0, 0);
        pulse(abort);
        step(1);
        `CHK(busy, 0);
      end
      step(3);
      $display("row %0d done", i);
    end
    slowMode = 0;
    // Pre type: convert from start until the edge
    setup(rows[1]);
    triggerType = 2'h1;
    samplePoints = 24'h000040;
    pulse(start);
    step(1);
    `CHK(convertEnable, 1);
    step(4);
    inputSideDigitalTriggerPin = 1;
    for (cyc = 0; cyc < 8 && convertEnable; cyc++) step(1);
    `CHK(convertEnable, 0);
    step(4);
    $display("pre type done");
    // Middle type, odd count: three after the edge
    setup(rows[1]);
    triggerType = 2'h2;
    samplePoints = 24'h000005;
    tr0 = trigCount; d0 = doneCount;
    pulse(start);
    step(30);
    inputSideDigitalTriggerPin = 1;
    // Snapshot after the edge that sees the event, before the first post sample
    step(1);
    t0 = takenCount;
    waitCnt(trigCount, tr0, 10);
    waitCnt(doneCount, d0, 40);
    `CHK(takenCount - t0, 3);
    step(3);
    $display("middle type done");
    // Delay type counted in timebase ticks
    setup(rows[0]);
    triggerType = 2'h3;
    samplePoints = 24'h000002;
    delayPreset = 31'h00000006;
    tr0 = trigCount; d0 = doneCount; mx = 0;
    pulse(start);
    waitCnt(trigCount, tr0, 10);
    t0 = takenCount;
    for (cyc = 0; cyc < 40 && !convertEnable; cyc++) begin
      step(1);
      if (delayRemaining > mx) mx = delayRemaining;
    end
    `CHK(mx, 31'h00000006);
    `CHK(cyc >= 11 && cyc <= 18, 1);
    waitCnt(doneCount, d0, 20);
    `CHK(takenCount - t0, 2);
    step(3);
    $display("delay type done");
    // Continuous mode refuses pre and middle, accepts post
    setup(rows[1]);
    continuousMode = 1;
    for (int k = 1; k <= 2; k++) begin
      triggerType = k[1:0];
      pulse(start);
      step(1);
      `CHK({configError, busy}, 2'h2);
    end
    triggerType = 2'h0;
    pulse(start);
    step(1);
    `CHK({configError, busy}, 2'h1);
    pulse(abort);
    step(1);
    `CHK({busy, convertEnable}, 2'h0);
    continuousMode = 0;
    $display("continuous mode done");
    // Reset in mid-run clears every output
    setup(rows[0]);
    samplePoints = 24'h000100;
    pulse(start);
    step(6);
    rstn = 0;
    step(2);
    `CHK({convertEnable, triggered, busy, done, configError}, 5'h00);
    `CHK(delayRemaining, 31'h00000000);
    rstn = 1;
    step(2);
    $display("reset done");
    endSim();
  end
endmodule

// ===== rtl/atc_analog_detect.sv
// Shared analog threshold detector for input and output conversion
`timescale 1ns/1ns
module atc_analog_detect (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic arm,
  input wire logic [2:0] analogSelect,
  input wire logic [1:0] analogCondition,
  input wire logic signed [15:0] highThreshold,
  input wire logic signed [15:0] lowThreshold,
  input wire logic signed [15:0] externalAnalogTriggerPin,
  input wire logic signed [15:0] analogChannelOne,
  input wire logic signed [15:0] analogChannelTwo,
  input wire logic signed [15:0] analogChannelThree,
  input wire logic signed [15:0] analogChannelFour,
  input wire logic [4:0] sampleValid,
  output logic hit
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic hit;    // One-cycle trigger pulse
    logic fired;  // Already fired since arm
  } atc_ad_t;

  atc_ad_t cur;
  atc_ad_t nxt;
  logic signed [15:0] level; // Selected sample
  logic fresh;               // New sample on selected source
  logic meet;                // Condition satisfied

  // Source mux and condition test
  always_comb begin
    level = externalAnalogTriggerPin;
    fresh = 1'b0;
    meet = 1'b0;
    case (analogSelect)
      3'h0: begin
        level = externalAnalogTriggerPin;
        fresh = sampleValid[0];
      end
      3'h1: begin
        level = analogChannelOne;
        fresh = sampleValid[1];
      end
      3'h2: begin
        level = analogChannelTwo;
        fresh = sampleValid[2];
      end
      3'h3: begin
        level = analogChannelThree;
        fresh = sampleValid[3];
      end
      3'h4: begin
        level = analogChannelFour;
        fresh = sampleValid[4];
      end
      default: begin
        fresh = 1'b0;
      end
    endcase
    case (atc_pkg::atc_cond_t'(analogCondition))
      atc_pkg::ATC_COND_ABOVE: meet = level > highThreshold;
      atc_pkg::ATC_COND_BELOW: meet = level < lowThreshold;
      // inside window; high above low assumed
      atc_pkg::ATC_COND_WINDOW: meet = (level > lowThreshold) && (level < highThreshold);
      default: meet = 1'b0;
    endcase
  end

  // Next-state: fire once per arm
  always_comb begin
    nxt = cur;
    nxt.hit = 1'b0;
    if (arm) begin
      nxt.fired = 1'b0;
    end else if (fresh && meet && !cur.fired) begin
      nxt.hit = 1'b1;
      nxt.fired = 1'b1;
    end
  end

  // Register
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  assign hit = cur.hit;

  property p_single_fire;
    @(posedge ref_clk) disable iff (!rstn) hit |=> !hit;
  endproperty
  a_single_fire: assert property (p_single_fire) else $error("analog hit held two cycles");

  property p_above;
    @(posedge ref_clk) disable iff (!rstn)
      (fresh && !arm && !cur.fired && analogCondition == 2'h0 && level > highThreshold) |=> hit;
  endproperty
  a_above: assert property (p_above) else $error("above-high sample did not fire");

endmodule

// ===== rtl/atc_delay_counter.sv
// Loadable 31-bit delay down-counter run by timebase ticks
`timescale 1ns/1ns
module atc_delay_counter (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic load,
  input wire logic [30:0] preset,
  input wire logic tick,
  output logic [30:0] count,
  output logic expired
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [30:0] count; // Remaining ticks
    logic running;      // Counting in progress
    logic expired;      // One-cycle end pulse
  } atc_dc_t;

  atc_dc_t cur;
  atc_dc_t nxt;

  // Next-state
  always_comb begin
    nxt = cur;
    nxt.expired = 1'b0;
    if (load) begin
      nxt.count = preset;
      nxt.running = 1'b1;
    end else if (cur.running) begin
      if (cur.count == atc_pkg::DELAY_RESET) begin
        nxt.running = 1'b0;
        nxt.expired = 1'b1;
      end else if (tick) begin
        nxt.count = cur.count - 31'h00000001;
      end
    end
  end

  // Register
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  assign count = cur.count;
  assign expired = cur.expired;

  property p_halt;
    @(posedge ref_clk) disable iff (!rstn) (expired && !load) |=> (count == 31'h00000000 && !expired);
  endproperty
  a_halt: assert property (p_halt) else $error("delay counter moved after zero");

  property p_dec;
    @(posedge ref_clk) disable iff (!rstn)
      (cur.running && !load && tick && count != 31'h00000000) |=> count == $past(count) - 31'h00000001;
  endproperty
  a_dec: assert property (p_dec) else $error("delay counter did not step down");

endmodule

// ===== rtl/atc_pkg.sv
// Package of constants and types for the acquisition trigger controller
package atc_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int SAMPLE_W = 16;            // Digitized sample width
  localparam int COUNT_W = 24;             // Sample count width
  localparam int DELAY_W = 31;             // Delay down-counter width

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int INT_TIMEBASE_MHZ = 48;    // Internal timebase rate
  localparam int EXT_TIMEBASE_MIN_MHZ = 1; // Slowest external timebase
  localparam int REF_CLK_MHZ = 125;        // Fabric clock rate

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [DELAY_W-1:0] DELAY_RESET = 31'h00000000;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 24'h000000;

  // Trigger source
  typedef enum logic [1:0] {
    ATC_SRC_NONE = 2'h0,
    ATC_SRC_DIGITAL = 2'h1,
    ATC_SRC_ANALOG = 2'h2,
    ATC_SRC_STAR = 2'h3
  } atc_src_t;

  // Trigger type
  typedef enum logic [1:0] {
    ATC_TYPE_POST = 2'h0,
    ATC_TYPE_PRE = 2'h1,
    ATC_TYPE_MID = 2'h2,
    ATC_TYPE_DELAY = 2'h3
  } atc_type_t;

  // Analog condition
  typedef enum logic [1:0] {
    ATC_COND_ABOVE = 2'h0,
    ATC_COND_BELOW = 2'h1,
    ATC_COND_WINDOW = 2'h2
  } atc_cond_t;

  // Analog input selector
  localparam logic [2:0] ASEL_EXT = 3'h0;   // External analog trigger pin
  localparam logic [2:0] ASEL_CH1 = 3'h1;   // First channel; channels 1..4 follow

  // Sequencer state
  typedef enum logic [2:0] {
    ATC_ST_IDLE = 3'h0,
    ATC_ST_ARMED = 3'h1,
    ATC_ST_PRE = 3'h2,
    ATC_ST_DELAY = 3'h3,
    ATC_ST_POST = 3'h4,
    ATC_ST_DONE = 3'h5
  } atc_state_t;

endpackage

// ===== rtl/atc_trigger_control.sv
// Acquisition trigger controller top: source, type and sample sequencing
//
// Operation
// - Four sources: none, digital, analog, star
// - One analog detector serves input and output
// - Star source taken from chassis trigger line
// - Analog from pin or channel; digital two pins
// - Types pre, post, middle, delay selectable
// - Pre: convert from start until trigger
// - Middle: half samples before, the rest after
// - Post default; count samples after trigger
// - Delay: load 31-bit counter, count timebase
// - Counter halts at zero, acquisition starts
// - Delay range scales with timebase rate
// - Digital positive rising, negative falling edge
// - Above high fires over high threshold
// - Below low fires under low threshold
// - Window fires between both thresholds
// - Continuous mode refuses pre and middle
`timescale 1ns/1ns
module atc_trigger_control (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic abort,
  input wire logic continuousMode,
  input wire logic [1:0] triggerSource,
  input wire logic [1:0] triggerType,
  input wire logic digitalSelectOutputSide,
  input wire logic digitalNegative,
  input wire logic [2:0] analogSelect,
  input wire logic [1:0] analogCondition,
  input wire logic signed [15:0] highThreshold,
  input wire logic signed [15:0] lowThreshold,
  input wire logic [23:0] samplePoints,
  input wire logic [30:0] delayPreset,
  input wire logic timebaseTick,
  input wire logic inputSideDigitalTriggerPin,
  input wire logic outputSideDigitalTriggerPin,
  input wire logic starTrigger,
  input wire logic signed [15:0] externalAnalogTriggerPin,
  input wire logic signed [15:0] analogChannelOne,
  input wire logic signed [15:0] analogChannelTwo,
  input wire logic signed [15:0] analogChannelThree,
  input wire logic signed [15:0] analogChannelFour,
  input wire logic [4:0] sampleValid,
  input wire logic sampleTaken,
  output logic convertEnable,
  output logic triggered,
  output logic busy,
  output logic done,
  output logic configError,
  output logic [30:0] delayRemaining
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    atc_pkg::atc_state_t state; // Sequencer state
    logic [23:0] remain;        // Samples still to take
    logic digPrev;              // Previous digital pin level
    logic starPrev;             // Previous star line level
    logic arm;                  // Re-arm pulse to analog detector
    logic loadDelay;            // Load pulse to delay counter
    logic convertEnable;        // Conversion gate
    logic triggered;            // Trigger event pulse
    logic done;                 // Acquisition finished pulse
    logic configError;          // Refused configuration
    logic busy;                 // Sequencer not idle
    logic [30:0] delayRemaining; // Mirrored counter value
  } atc_top_t;

  atc_top_t cur;
  atc_top_t next_cur;
  logic analogHit;   // From shared analog detector
  logic delayDone;   // From delay counter
  logic [30:0] delayCount; // Counter value
  logic digLevel;    // Selected digital pin
  logic digEdge;     // Qualified digital edge
  logic event_;      // Trigger event from chosen source
  logic [23:0] half; // Half of sample points

  // ----------------------------------------
  // Shared analog detector and delay counter
  // ----------------------------------------
  // one detector for both conversions
  atc_analog_detect u_analog (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .arm(cur.arm),
    .analogSelect(analogSelect),
    .analogCondition(analogCondition),
    .highThreshold(highThreshold),
    .lowThreshold(lowThreshold),
    .externalAnalogTriggerPin(externalAnalogTriggerPin),
    .analogChannelOne(analogChannelOne),
    .analogChannelTwo(analogChannelTwo),
    .analogChannelThree(analogChannelThree),
    .analogChannelFour(analogChannelFour),
    .sampleValid(sampleValid),
    .hit(analogHit)
  );

  // delay counts timebase ticks, any rate
  atc_delay_counter u_delay (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .load(cur.loadDelay),
    .preset(delayPreset),
    .tick(timebaseTick),
    .count(delayCount),
    .expired(delayDone)
  );

  // Edge detect on selected digital pin
  function automatic logic atc_edge(input logic prev, input logic now, input logic neg);
    atc_edge = neg ? (prev && !now) : (!prev && now);
  endfunction

  // Event selection
  always_comb begin
    digLevel = digitalSelectOutputSide ? outputSideDigitalTriggerPin : inputSideDigitalTriggerPin;
    digEdge = atc_edge(cur.digPrev, digLevel, digitalNegative);
    half = {1'b0, samplePoints[23:1]};
    case (atc_pkg::atc_src_t'(triggerSource))
      atc_pkg::ATC_SRC_NONE: event_ = 1'b1;
      atc_pkg::ATC_SRC_DIGITAL: event_ = digEdge;
      atc_pkg::ATC_SRC_ANALOG: event_ = analogHit;
      atc_pkg::ATC_SRC_STAR: event_ = atc_edge(cur.starPrev, starTrigger, 1'b0);
      default: event_ = 1'b0;
    endcase
  end

  // Sequencer next-state
  always_comb begin
    next_cur = cur;
    next_cur.digPrev = digLevel;
    next_cur.starPrev = starTrigger;
    next_cur.arm = 1'b0;
    next_cur.loadDelay = 1'b0;
    next_cur.triggered = 1'b0;
    next_cur.done = 1'b0;
    next_cur.delayRemaining = delayCount;
    case (cur.state)
      atc_pkg::ATC_ST_IDLE: begin
        if (start) begin
          // refuse pre and middle in continuous
          if (continuousMode && (triggerType == 2'h1 || triggerType == 2'h2)) begin
            next_cur.configError = 1'b1;
          end else begin
            next_cur.configError = 1'b0;
            next_cur.arm = 1'b1;
            next_cur.remain = samplePoints;
            case (atc_pkg::atc_type_t'(triggerType))
              atc_pkg::ATC_TYPE_PRE: begin
                next_cur.state = atc_pkg::ATC_ST_PRE;
                next_cur.convertEnable = 1'b1;
              end
              atc_pkg::ATC_TYPE_MID: begin
                next_cur.state = atc_pkg::ATC_ST_PRE;
                next_cur.convertEnable = 1'b1;
                next_cur.remain = half;
              end
              default: next_cur.state = atc_pkg::ATC_ST_ARMED;
            endcase
          end
        end
      end
      atc_pkg::ATC_ST_PRE: begin
        // Pre-trigger history; count down the first half for middle
        if (sampleTaken && cur.remain != atc_pkg::COUNT_RESET) begin
          next_cur.remain = cur.remain - 24'h000001;
        end
        if (event_ && !cur.arm) begin
          next_cur.triggered = 1'b1;
          if (triggerType == 2'h2) begin
            next_cur.remain = samplePoints - half;
            next_cur.state = atc_pkg::ATC_ST_POST;
          end else begin
            next_cur.convertEnable = 1'b0;
            next_cur.done = 1'b1;
            next_cur.state = atc_pkg::ATC_ST_DONE;
          end
        end
      end
      atc_pkg::ATC_ST_ARMED: begin
        if (event_ && !cur.arm) begin
          next_cur.triggered = 1'b1;
          if (triggerType == 2'h3) begin
            next_cur.loadDelay = 1'b1;
            next_cur.state = atc_pkg::ATC_ST_DELAY;
          end else begin
            next_cur.convertEnable = 1'b1;
            next_cur.state = atc_pkg::ATC_ST_POST;
          end
        end
      end
      atc_pkg::ATC_ST_DELAY: begin
        if (delayDone) begin
          next_cur.convertEnable = 1'b1;
          next_cur.state = atc_pkg::ATC_ST_POST;
        end
      end
      atc_pkg::ATC_ST_POST: begin
        if (sampleTaken && !continuousMode) begin
          next_cur.remain = cur.remain - 24'h000001;
          if (cur.remain <= 24'h000001) begin
            next_cur.convertEnable = 1'b0;
            next_cur.done = 1'b1;
            next_cur.state = atc_pkg::ATC_ST_DONE;
          end
        end
      end
      atc_pkg::ATC_ST_DONE: begin
        next_cur.state = atc_pkg::ATC_ST_IDLE;
      end
      default: next_cur.state = atc_pkg::ATC_ST_IDLE;
    endcase
    if (abort) begin
      next_cur.state = atc_pkg::ATC_ST_IDLE;
      next_cur.convertEnable = 1'b0;
    end
    // Busy flag registered from the state being entered
    next_cur.busy = (next_cur.state != atc_pkg::ATC_ST_IDLE);
  end

  // Register; reset leaves post type decided by software input
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign convertEnable = cur.convertEnable;
  assign triggered = cur.triggered;
  assign busy = cur.busy;
  assign done = cur.done;
  assign configError = cur.configError;
  assign delayRemaining = cur.delayRemaining;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_delay_wait;
    cur.state == atc_pkg::ATC_ST_DELAY && !convertEnable;
  endsequence

  property p_pre_stop;
    @(posedge ref_clk) disable iff (!rstn)
      (cur.state == atc_pkg::ATC_ST_PRE && triggerType == 2'h1 && event_ && !cur.arm && !abort) |=> !convertEnable && done;
  endproperty
  a_pre_stop: assert property (p_pre_stop) else $error("pre-trigger kept converting");

  property p_cont_refuse;
    @(posedge ref_clk) disable iff (!rstn)
      (cur.state == atc_pkg::ATC_ST_IDLE && start && continuousMode && triggerType == 2'h1) |=> configError && !busy;
  endproperty
  a_cont_refuse: assert property (p_cont_refuse) else $error("pre accepted in continuous");

  property p_delay_start;
    @(posedge ref_clk) disable iff (!rstn) (s_delay_wait ##0 (delayDone && !abort)) |=> convertEnable;
  endproperty
  a_delay_start: assert property (p_delay_start) else $error("no start after delay");

  property p_post_start;
    @(posedge ref_clk) disable iff (!rstn)
      (cur.state == atc_pkg::ATC_ST_ARMED && triggerType == 2'h0 && event_ && !cur.arm && !abort) |=> convertEnable && triggered;
  endproperty
  a_post_start: assert property (p_post_start) else $error("post did not start");

  property p_dig_rise;
    @(posedge ref_clk) disable iff (!rstn)
      (triggerSource == 2'h1 && !digitalNegative && !cur.digPrev && digLevel) |-> event_;
  endproperty
  a_dig_rise: assert property (p_dig_rise) else $error("rising edge missed");

  property p_delay_load;
    @(posedge ref_clk) disable iff (!rstn)
      (cur.state == atc_pkg::ATC_ST_ARMED && triggerType == 2'h3 && event_ && !cur.arm && !abort) |=> ##1 (delayCount == $past(delayPreset));
  endproperty
  a_delay_load: assert property (p_delay_load) else $error("delay not loaded");

endmodule
